// file: design/tbl_loader.sv
// tile boot sequencer: security word load, image load, crc check, otp programming gate
`timescale 1ns/10ps
module tbl_loader
  import tbl_pkg::*;
#(
  parameter int RAM_AW = 16  // ram word address width
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // avalon-mm slave
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // otp read port
  output logic             otp_rd_req,
  output logic      [10:0] otp_rd_addr,
  input  wire logic [31:0] otp_rd_data,
  input  wire logic        otp_rd_valid,
  // otp programming port
  output logic             otp_pg_req,
  output logic      [15:0] otp_pg_addr,
  output logic      [31:0] otp_pg_data,
  output logic      [15:0] otp_pg_ctrl,
  input  wire logic        otp_pg_done,
  // embedded flash byte stream
  output logic             flash_en,
  input  wire logic        flash_valid,
  input  wire logic [7:0]  flash_data,
  output logic             flash_ready,
  // ram write port
  output logic             ram_we,
  output logic [RAM_AW-1:0] ram_addr,
  output logic      [31:0] ram_wdata,
  // processor start
  output logic             exec_start,
  output logic      [31:0] exec_addr,
  output logic             core_run,
  output logic             boot_fail,
  // pins and security controls
  output logic             gpio_pulldown,
  output logic             jtag_tile_block,
  output logic             link_access_block,
  output logic             otp_redundant_en,
  output logic             otp_jtag_block,
  output logic             debug_pin_disable,
  output logic      [6:0]  sec_gp_bits,
  output logic      [9:0]  usercode_ext
);

  // elaboration check: ram must hold at least two words, at most 2^30
  if (RAM_AW < 1 || RAM_AW > 30) begin : g_bad_aw
    $error("RAM_AW out of range");
  end

  localparam logic [31:0] RAM_WORDS = 32'(1) << RAM_AW;

  // ****************************************
  // crc helper
  // ****************************************
  // one byte of reflected crc, lsb first
  function automatic logic [31:0] crc_upd(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    r = c ^ {24'h00_0000, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // ****************************************
  // declarations
  // ****************************************
  tbl_state_t   state;          // boot sequencer
  tbl_phase_t   phase;          // image field
  tbl_sec_t     sec;            // security word
  logic         sec_loaded;     // security word valid
  logic         src_otp;        // image comes from otp
  logic [7:0]   dly;            // reset delay counter
  logic [1:0]   bcnt;           // byte within word
  logic [31:0]  asm_w;          // word under assembly
  logic [31:0]  size;           // program size in words
  logic [31:0]  chk;            // stored check word
  logic [31:0]  crc;            // running crc
  logic [31:0]  wcnt;           // words written to ram
  logic         rd_pend;        // otp read outstanding
  logic [10:0]  img_row;        // next otp image row
  logic [31:0]  obuf;           // otp word being split
  logic [2:0]   ocnt;           // bytes left in obuf
  logic         ack;            // bus answer cycle
  logic [15:0]  pg_addr;        // programming address
  logic [31:0]  pg_data;        // programming data
  logic         pg_busy;        // programming in flight
  logic         pg_rej;         // sticky refusal
  logic         in_valid;       // byte available
  logic [7:0]   in_byte;        // current byte
  logic         take;           // byte consumed
  logic [31:0]  nxt_w;          // word incl. current byte
  logic         need_sec;       // fetch security row
  logic         need_img;       // fetch image row
  logic         crc_ok;         // check passes
  logic         wr_fire;        // bus write takes effect
  logic         go;             // programming request
  logic         locked;         // programming refused

  // ****************************************
  // byte source mux
  // ****************************************
  // otp words are split into bytes, least first, so both sources parse alike
  always_comb begin
    in_valid = src_otp ? (ocnt != 3'd0) : flash_valid;
    in_byte  = src_otp ? obuf[7:0] : flash_data;
    take     = (state == ST_LOAD) && in_valid;
    nxt_w    = {in_byte, asm_w[31:8]};
    need_sec = (state == ST_SEC_RD);
    need_img = (state == ST_LOAD) && src_otp && (ocnt == 3'd0); // check word row fetched as well
    crc_ok   = (chk == CRC_BYPASS) || (~crc == chk);
  end

  // flash only drains while loading from flash
  assign flash_ready = (state == ST_LOAD) && !src_otp;

  // ****************************************
  // reset pin behaviour
  // ****************************************
  // pull-downs stay on through reset, released on first clock after
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      gpio_pulldown <= 1'b1;
    end else begin
      gpio_pulldown <= 1'b0;
    end
  end

  // ****************************************
  // boot sequencer
  // ****************************************
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state      <= ST_DELAY;
      phase      <= PH_SIZE;
      dly        <= 8'(BOOT_DLY_CYC - 1);
      sec        <= tbl_sec_t'(SEC_RST);
      sec_loaded <= 1'b0;
      src_otp    <= 1'b0;
      bcnt       <= 2'd0;
      asm_w      <= 32'h0000_0000;
      size       <= 32'h0000_0000;
      chk        <= 32'h0000_0000;
      boot_fail  <= 1'b0;
    end else begin
      case (state)
        // internal reset delay; reset source keeps supply settle time
        ST_DELAY: begin
          if (dly == 8'd0) begin
            state <= ST_SEC_RD;
          end else begin
            dly <= dly - 8'd1;
          end
        end
        // security word before any boot decision
        ST_SEC_RD: begin
          if (otp_rd_valid) begin
            sec        <= tbl_sec_t'(otp_rd_data);
            sec_loaded <= 1'b1;
            src_otp    <= otp_rd_data[5];
            state      <= ST_LOAD;
          end
        end
        // parse size, program, check word
        ST_LOAD: begin
          if (take) begin
            asm_w <= nxt_w;
            bcnt  <= bcnt + 2'd1;
            if (bcnt == 2'd3) begin
              case (phase)
                PH_SIZE: begin
                  size <= nxt_w;
                  if (nxt_w > RAM_WORDS) begin
                    state     <= ST_FAIL; // image cannot fit
                    boot_fail <= 1'b1;
                  end else if (nxt_w == 32'h0000_0000) begin
                    phase <= PH_CHK;
                  end else begin
                    phase <= PH_PROG;
                  end
                end
                PH_PROG: begin
                  if (wcnt + 32'd1 == size) begin
                    phase <= PH_CHK;
                  end
                end
                default: begin
                  chk   <= nxt_w;
                  state <= ST_CHECK;
                end
              endcase
            end
          end
        end
        // compare stored and computed check value
        ST_CHECK: begin
          if (crc_ok) begin
            state <= ST_RUN;
          end else begin
            state     <= ST_FAIL;
            boot_fail <= 1'b1;
          end
        end
        // terminal states until next reset
        ST_RUN: begin
          state <= ST_RUN;
        end
        default: begin
          state <= ST_FAIL;
        end
      endcase
    end
  end

  // ****************************************
  // otp read requests
  // ****************************************
  // one read outstanding; answer expected at least one cycle after request
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      otp_rd_req  <= 1'b0;
      otp_rd_addr <= 11'h000;
      rd_pend     <= 1'b0;
      img_row     <= IMG_ROW0;
    end else begin
      otp_rd_req <= 1'b0;
      if (otp_rd_req) begin
        rd_pend <= 1'b1;
      end else if (otp_rd_valid) begin
        rd_pend <= 1'b0;
      end
      if ((need_sec || need_img) && !rd_pend && !otp_rd_req) begin
        otp_rd_req <= 1'b1;
        if (need_sec) begin
          otp_rd_addr <= SEC_ROW;
        end else begin
          otp_rd_addr <= img_row;
          img_row     <= img_row + 11'd1;
        end
      end
    end
  end

  // ****************************************
  // otp word splitter
  // ****************************************
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      obuf <= 32'h0000_0000;
      ocnt <= 3'd0;
    end else if (state == ST_LOAD && src_otp && otp_rd_valid) begin
      obuf <= otp_rd_data;
      ocnt <= 3'd4;
    end else if (take && src_otp) begin
      obuf <= obuf >> 8;
      ocnt <= ocnt - 3'd1;
    end
  end

  // flash enabled only while the image streams from it
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      flash_en <= 1'b0;
    end else begin
      flash_en <= (state == ST_LOAD) && !src_otp;
    end
  end

  // ****************************************
  // crc over size and program bytes
  // ****************************************
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      crc <= CRC_INIT;
    end else if (take && phase != PH_CHK) begin
      crc <= crc_upd(crc, in_byte);
    end
  end

  // ****************************************
  // ram writes
  // ****************************************
  // word address counts up from the base
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ram_we    <= 1'b0;
      ram_addr  <= '0;
      ram_wdata <= 32'h0000_0000;
      wcnt      <= 32'h0000_0000;
    end else begin
      ram_we <= 1'b0;
      if (take && phase == PH_PROG && bcnt == 2'd3) begin
        ram_we    <= 1'b1;
        ram_addr  <= RAM_BASE[RAM_AW+1:2] + wcnt[RAM_AW-1:0];
        ram_wdata <= nxt_w;
        wcnt      <= wcnt + 32'd1;
      end
    end
  end

  // ****************************************
  // processor start
  // ****************************************
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      exec_start <= 1'b0;
      exec_addr  <= 32'h0000_0000;
      core_run   <= 1'b0;
    end else begin
      exec_start <= (state == ST_CHECK) && crc_ok;
      if (state == ST_CHECK && crc_ok) begin
        exec_addr <= RAM_BASE;
        core_run  <= 1'b1;
      end
    end
  end

  // ****************************************
  // security controls
  // ****************************************
  // reset value keeps everything closed until the word arrives
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      jtag_tile_block   <= 1'b1;
      link_access_block <= 1'b1;
      otp_redundant_en  <= 1'b0;
      otp_jtag_block    <= 1'b1;
      debug_pin_disable <= 1'b1;
      sec_gp_bits       <= 7'h00;
      usercode_ext      <= 10'h000;
    end else begin
      jtag_tile_block   <= sec.jtag_dis;
      link_access_block <= sec.link_dis;
      otp_redundant_en  <= sec.redundant && sec_loaded;
      otp_jtag_block    <= sec.jtag_otp_dis;
      debug_pin_disable <= sec.dbg_pin_dis;
      sec_gp_bits       <= sec.gp;
      usercode_ext      <= sec.uid_ext;
    end
  end

  // ****************************************
  // avalon-mm slave
  // ****************************************
  // every access waits one cycle: request in cycle 0, answer in cycle 1
  assign avs_waitrequest = (avs_read || avs_write) && !ack;
  assign wr_fire         = avs_write && ack;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read || avs_write) && !ack;
    end
  end

  // read data registered in the wait cycle, stands at the answer edge
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack) begin
      if (avs_address == REG_SEC) begin
        avs_readdata <= sec;
      end else if (avs_address == REG_STATUS) begin
        avs_readdata <= {24'h00_0000, sec_loaded, pg_rej, pg_busy, boot_fail, core_run, state};
      end else if (avs_address == REG_PG_ADDR) begin
        avs_readdata <= {16'h0000, pg_addr};
      end else if (avs_address == REG_PG_DATA) begin
        avs_readdata <= pg_data;
      end else if (avs_address == REG_WORDS) begin
        avs_readdata <= wcnt;
      end else if (avs_address == REG_CRC) begin
        avs_readdata <= ~crc;
      end else begin
        avs_readdata <= 32'h0000_0000; // unmapped and write-only
      end
    end
  end

  // ****************************************
  // otp programming gate
  // ****************************************
  // sector from row address; rows past the array are refused as well
  always_comb begin
    go     = wr_fire && avs_address == REG_PG_CTRL && avs_byteenable[0] && avs_writedata[CTRL_GO];
    locked = !sec_loaded || pg_busy || sec.master_lock
             || sec.sector_lock[pg_addr[10:9]]
             || (pg_addr >= 16'(OTP_ROWS));
  end

  // address and data ports, byte lanes honoured
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pg_addr <= 16'h0000;
      pg_data <= 32'h0000_0000;
    end else if (wr_fire) begin
      for (int i = 0; i < 4; i++) begin
        if (avs_byteenable[i] && avs_address == REG_PG_DATA) begin
          pg_data[i*8 +: 8] <= avs_writedata[i*8 +: 8];
        end
        if (i < 2 && avs_byteenable[i] && avs_address == REG_PG_ADDR) begin
          pg_addr[i*8 +: 8] <= avs_writedata[i*8 +: 8];
        end
      end
    end
  end

  // control port launches a write; refusal is sticky, set beats clear
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      otp_pg_req  <= 1'b0;
      otp_pg_addr <= 16'h0000;
      otp_pg_data <= 32'h0000_0000;
      otp_pg_ctrl <= 16'h0000;
      pg_busy     <= 1'b0;
      pg_rej      <= 1'b0;
    end else begin
      otp_pg_req <= 1'b0;
      if (otp_pg_done) begin
        pg_busy <= 1'b0;
      end
      if (go && locked) begin
        pg_rej <= 1'b1;
      end else if (go) begin
        otp_pg_req  <= 1'b1;
        otp_pg_addr <= pg_addr;
        otp_pg_data <= pg_data;
        otp_pg_ctrl <= avs_writedata[15:0];
        pg_busy     <= 1'b1;
      end else if (wr_fire && avs_address == REG_PG_CTRL && avs_byteenable[0]
                   && avs_writedata[CTRL_CLR]) begin
        pg_rej <= 1'b0;
      end
    end
  end

endmodule

// file: design/tbl_pkg.sv
// package: constants and types for the tile boot and security loader
package tbl_pkg;

  // ****************************************
  // clock and boot timing
  // ****************************************
  localparam int CLK_NS       = 100;      // sys_clk period
  localparam int BOOT_DLY_NS  = 15000;    // least internal reset time, 15 us
  localparam int BOOT_DLY_CYC = (BOOT_DLY_NS + CLK_NS - 1) / CLK_NS;

  // ****************************************
  // otp geometry and image format
  // ****************************************
  localparam int          OTP_SECTORS  = 4;
  localparam int          OTP_SEC_ROWS = 512;
  localparam int          OTP_ROWS     = OTP_SECTORS * OTP_SEC_ROWS;
  localparam logic [10:0] SEC_ROW      = 11'h7FF;       // row holding the security word
  localparam logic [10:0] IMG_ROW0     = 11'h000;       // secure image starts at row 0
  localparam logic [31:0] CRC_BYPASS   = 32'h0D15_AB1E;
  localparam logic [31:0] CRC_POLY     = 32'hEDB8_8320;
  localparam logic [31:0] CRC_INIT     = 32'hFFFF_FFFF;
  localparam logic [31:0] RAM_BASE     = 32'h0000_0000; // load and start address
  localparam logic [31:0] SEC_RST      = 32'h0000_7FFF; // locked down until loaded

  // ****************************************
  // programming port resource identifiers
  // ****************************************
  localparam logic [23:0] RID_PG_ADDR = 24'h10_0200;
  localparam logic [23:0] RID_PG_DATA = 24'h20_0100;
  localparam logic [23:0] RID_PG_CTRL = 24'h10_0300;

  // ****************************************
  // register map, byte addresses
  // ****************************************
  localparam logic [7:0] REG_SEC     = 8'h00;
  localparam logic [7:0] REG_STATUS  = 8'h04;
  localparam logic [7:0] REG_PG_ADDR = 8'h08;
  localparam logic [7:0] REG_PG_DATA = 8'h0C;
  localparam logic [7:0] REG_PG_CTRL = 8'h10;
  localparam logic [7:0] REG_WORDS   = 8'h14;
  localparam logic [7:0] REG_CRC     = 8'h18;
  localparam int         CTRL_GO     = 0;
  localparam int         CTRL_CLR    = 1;

  // ****************************************
  // security word layout, bit 31 first
  // ****************************************
  typedef struct packed {
    logic [9:0] uid_ext;       // 31:22
    logic [6:0] gp;            // 21:15
    logic       dbg_pin_dis;   // 14
    logic       jtag_otp_dis;  // 13
    logic       master_lock;   // 12
    logic [3:0] sector_lock;   // 11:8
    logic       redundant;     // 7
    logic       rsv6;          // 6
    logic       secure_boot;   // 5
    logic [2:0] rsv4_2;        // 4:2
    logic       link_dis;      // 1
    logic       jtag_dis;      // 0
  } tbl_sec_t;

  // boot sequencer states
  typedef enum logic [2:0] {
    ST_DELAY  = 3'b000,
    ST_SEC_RD = 3'b001,
    ST_LOAD   = 3'b010,
    ST_CHECK  = 3'b011,
    ST_RUN    = 3'b100,
    ST_FAIL   = 3'b101
  } tbl_state_t;

  // image field being parsed
  typedef enum logic [1:0] {
    PH_SIZE = 2'b00,
    PH_PROG = 2'b01,
    PH_CHK  = 2'b10
  } tbl_phase_t;

endpackage

// file: verification/tbl_mem_model.sv
// behavioural otp array and embedded flash byte stream facing the loader
`timescale 1ns/10ps
module tbl_mem_model
  import tbl_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // otp read and programming
  input  wire logic        otp_rd_req,
  input  wire logic [10:0] otp_rd_addr,
  output logic      [31:0] otp_rd_data,
  output logic             otp_rd_valid,
  input  wire logic        otp_pg_req,
  output logic             otp_pg_done,
  // flash byte stream
  input  wire logic        flash_en,
  input  wire logic        flash_ready,
  output logic             flash_valid,
  output logic      [7:0]  flash_data
);
  logic [31:0] otp [0:OTP_ROWS-1]; // four sectors of 512 rows
  logic [7:0]  fl [0:255];         // flash image, lsb first
  logic [10:0] ra;                 // row being answered
  logic [1:0]  rc;                 // answer countdown
  logic [1:0]  pg;                 // programming delay line
  int          idx;                // next flash byte
  // otp answers 1 to 3 cycles late, so the loader cannot count on latency
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rc <= 2'd0;
      otp_rd_valid <= 1'b0;
    end else begin
      otp_rd_valid <= (rc == 2'd1);
      if (otp_rd_req) begin
        ra <= otp_rd_addr;
        rc <= 2'($urandom_range(1, 3));
      end else if (rc != 2'd0) begin
        rc <= rc - 2'd1;
      end
    end
  end
  // data garbled outside the valid cycle, never a stale copy
  assign otp_rd_data = otp_rd_valid ? otp[ra] : ~otp[ra];
  // programming finishes a few cycles after each request
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pg <= 2'd0;
      otp_pg_done <= 1'b0;
    end else begin
      pg <= {pg[0], otp_pg_req};
      otp_pg_done <= pg[1];
    end
  end
  // flash stalls one cycle in four; a byte stands until taken
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst || flash_en !== 1'b1) begin
      idx <= 0;
      flash_valid <= 1'b0;
    end else begin
      if (flash_valid && flash_ready) idx <= idx + 1;
      if (!flash_valid || flash_ready) flash_valid <= ($urandom_range(0, 3) != 0);
    end
  end
  assign flash_data = flash_valid ? fl[idx] : ~fl[idx];
endmodule

// file: verification/tbl_loader_monitor.sv
// checker watching the boot loader ports
`timescale 1ns/10ps
module tbl_loader_monitor
  import tbl_pkg::*;
(
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  // bus and memories
  input wire logic        avs_read,
  input wire logic        avs_waitrequest,
  input wire logic        otp_rd_req,
  input wire logic [10:0] otp_rd_addr,
  input wire logic        flash_en,
  input wire logic        flash_ready,
  input wire logic        ram_we,
  // start and pins
  input wire logic        exec_start,
  input wire logic [31:0] exec_addr,
  input wire logic        core_run,
  input wire logic        boot_fail,
  input wire logic        gpio_pulldown
);
  logic [15:0] cnt;  // edges since release, saturating
  logic        seen; // first otp read already made
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // helper state, cleared by every reset
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt <= 16'h0000;
      seen <= 1'b0;
    end else begin
      if (cnt != 16'hFFFF) cnt <= cnt + 16'h0001;
      if (otp_rd_req) seen <= 1'b1;
    end
  end
  AST_BOOT_DLY: assert property (otp_rd_req && !seen |-> cnt >= 149 && cnt <= 1500) else $error("boot early");
  AST_SEC_FIRST: assert property (otp_rd_req && !seen |-> otp_rd_addr == SEC_ROW) else $error("sec row");
  AST_SRC: assert property (flash_ready |=> flash_en) else $error("flash src");
  AST_START_AT: assert property (exec_start |-> exec_addr == RAM_BASE && core_run) else $error("start");
  AST_START_ONE: assert property (exec_start |=> !exec_start && core_run) else $error("pulse");
  AST_FAIL_HOLD: assert property (boot_fail |=> boot_fail && !core_run && !exec_start) else $error("fail");
  AST_WAIT_ONE: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest) else $error("wait");
  AST_PULL_OFF: assert property (!$past(sys_rst) |-> !gpio_pulldown) else $error("pulldown");
  AST_LOAD_DONE: assert property (ram_we |-> !core_run && !boot_fail) else $error("late write");
endmodule
bind tbl_loader tbl_loader_monitor u_mon (.*);

// file: verification/tbl_loader_tb_top.sv
// self-checking bench for the boot loader
`timescale 1ns/10ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fail_count++; $display("unexpected t=%0t got=%h exp=%h", $time, a, b); end end
module tbl_loader_tb_top import tbl_pkg::*; ();
  logic        sys_clk, sys_rst, avs_read, avs_write, avs_waitrequest;
  logic [7:0]  avs_address, flash_data;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, otp_rd_data, otp_pg_data, ram_wdata, exec_addr, pgd;
  logic        otp_rd_req, otp_rd_valid, otp_pg_req, otp_pg_done, flash_en, flash_valid, flash_ready;
  logic [10:0] otp_rd_addr;
  logic [15:0] otp_pg_addr, otp_pg_ctrl, ram_addr, pga;
  logic        ram_we, exec_start, core_run, boot_fail, gpio_pulldown, jtag_tile_block;
  logic        link_access_block, otp_redundant_en, otp_jtag_block, debug_pin_disable;
  logic [6:0]  sec_gp_bits;
  logic [9:0]  usercode_ext;
  logic [31:0] img [0:63]; // current image words
  int          fail_count = 0, checks_done = 0, widx, pg_cnt;
  tbl_loader u_dut (.*);
  tbl_mem_model u_mem (.*);
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // reflected crc, bytes and bits lsb first
  function automatic logic [31:0] crc_of(input int s);
    logic [31:0] c;
    c = CRC_INIT;
    for (int i = 0; i <= s; i++)
      for (int k = 0; k < 32; k++) c = (c[0] ^ img[i][k]) ? (c >> 1) ^ CRC_POLY : c >> 1;
    return ~c;
  endfunction
  // avalon cycle: hold until waitrequest seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0 && n < 20) begin
      n++;
      @(posedge sys_clk);
    end
    if (n == 20) fail_count++;
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask
  // one boot: mode 0 good crc, 1 bad crc, 2 bypass
  task automatic boot(input logic [31:0] sec, input int s, input int mode);
    logic [31:0] q;
    logic        rej;
    int          n;
    img[0] = s;
    for (int i = 1; i <= s; i++) img[i] = $urandom;
    img[s+1] = (mode == 2) ? CRC_BYPASS : crc_of(s) ^ 32'(mode == 1);
    u_mem.otp[SEC_ROW] = sec;
    for (int i = 0; i <= s + 1; i++) begin
      u_mem.otp[IMG_ROW0 + i] = img[i];
      for (int k = 0; k < 4; k++) u_mem.fl[4*i+k] = img[i][8*k +: 8];
    end
    sys_rst <= 1'b1;
    widx = 0;
    repeat (3) @(posedge sys_clk);
    `CHK(gpio_pulldown, 1'b1)
    sys_rst <= 1'b0;
    for (n = 0; n < 4000 && exec_start !== 1'b1 && boot_fail !== 1'b1; n++) @(negedge sys_clk);
    `CHK(boot_fail, 1'(mode == 1))
    `CHK(exec_start, 1'(mode != 1))
    `CHK(widx, s)
    `CHK({usercode_ext, sec_gp_bits, debug_pin_disable, otp_jtag_block}, sec[31:13])
    `CHK({otp_redundant_en, link_access_block, jtag_tile_block}, {sec[7], sec[1:0]})
    @(posedge sys_clk);
    bus(1'b0, REG_STATUS, 0, q);
    `CHK(q[7:0], {3'b100, 1'(mode == 1), 1'(mode != 1), (mode == 1) ? ST_FAIL : ST_RUN})
    bus(1'b1, REG_SEC, ~sec, q);
    bus(1'b0, REG_SEC, 0, q);
    `CHK(q, sec)
    bus(1'b0, REG_WORDS, 0, q);
    `CHK(q, s)
    bus(1'b0, 8'h40, 0, q);
    `CHK(q, 32'h0000_0000)
    pga = 16'($urandom_range(0, 2303));
    pgd = $urandom;
    rej = sec[12] | pga[11] | sec[8 + pga[10:9]];
    pg_cnt = 0;
    bus(1'b1, REG_PG_ADDR, pga, q);
    bus(1'b1, REG_PG_DATA, pgd, q);
    bus(1'b0, REG_PG_ADDR, 0, q);
    `CHK(q, {16'h0000, pga})
    bus(1'b1, REG_PG_CTRL, 32'h0000_0001, q);
    repeat (6) @(posedge sys_clk);
    bus(1'b0, REG_STATUS, 0, q);
    `CHK(q[6:5], {rej, 1'b0})
    `CHK(pg_cnt, int'(!rej))
    bus(1'b1, REG_PG_CTRL, 32'h0000_0002, q);
    bus(1'b0, REG_STATUS, 0, q);
    `CHK(q[6], 1'b0)
  endtask
  // ram writes against the image, programming requests against pga and pgd
  always @(posedge sys_clk) begin
    if (ram_we === 1'b1) begin
      `CHK(ram_addr, 16'(widx))
      `CHK(ram_wdata, img[widx+1])
      widx++;
    end
    if (otp_pg_req === 1'b1) begin
      pg_cnt++;
      `CHK({otp_pg_addr, otp_pg_data, otp_pg_ctrl}, {pga, pgd, 16'h0001})
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // watchdog, far beyond four boots
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    tally_and_finish();
  end
  initial begin
    sys_rst = 1'b1;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hF;
    void'($urandom(32'h9b4c_4914));
    boot($urandom & 32'hFFFF_EFDF, 5, 0);
    boot(($urandom | 32'h0000_0020) & 32'hFFFF_EFFF, 3, 2);
    boot($urandom & 32'hFFFF_EFDF, 0, 1);
    boot($urandom | 32'h0000_1020, 7, 0);
    tally_and_finish();
  end
endmodule
